//--- logic/itm_timer.sv
// one interval timer channel with an axi4-lite register slave
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module itm_timer
  import itm_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        CNT_CLK,
  input  wire logic        GATE,
  output logic             TMR_OUT
);

  // wave select decode; top bit ignored for modes 2 and 3
  function automatic itm_mode_t decode_mode(input logic [2:0] ws);
    itm_mode_t m;
    m = ITM_MODE0;
    case (ws)
      3'b000:  m = ITM_MODE0;
      3'b001:  m = ITM_MODE1;
      3'b010, 3'b110: m = ITM_MODE2;
      3'b011, 3'b111: m = ITM_MODE3;
      3'b100:  m = ITM_MODE4;
      3'b101:  m = ITM_MODE5;
      default: m = ITM_MODE0;
    endcase
    return m;
  endfunction

  // decrement by one, binary or four bcd digits with carry digit in bit 16
  function automatic logic [16:0] dec1(input logic [16:0] v, input logic bcd);
    logic [16:0] r;
    logic        brw;
    r   = v;
    brw = 1'b1;
    if (!bcd) begin
      r = v - ITM_CNT_ONE;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (brw) begin
          if (v[i*4 +: 4] == 4'h0) begin
            r[i*4 +: 4] = ITM_BCD_NINE;
          end else begin
            r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
            brw = 1'b0;
          end
        end
      end
      if (brw) begin
        r[16] = 1'b0;
      end
    end
    return r;
  endfunction

  // zero programmed count stands for the full range
  function automatic logic [16:0] eff_count(input logic [15:0] c);
    return (c == ITM_CR_RESET) ? ITM_CNT_MAX : {1'b0, c};
  endfunction

  // axi slave state
  logic        aw_full_q, w_full_q, w_strb0_q, bvalid_q, rvalid_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [1:0]  bresp_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  // timer state
  itm_ctrl_t   ctrl_q;
  itm_mode_t   mode;
  logic [15:0] cr_q;
  logic [16:0] ce_q;
  logic        out_q, run_q, pend_q, hold_q, armed_q, strobe_q;
  logic        wr_msb_q, rd_msb_q, lat_q, cclk_prev_q, gate_prev_q;
  logic [15:0] lat_val_q;

  logic        tick, gate_rise, wr_exec, wr_ctrl, wr_data, rd_exec;
  logic        rd_data, cnt_done, count_en, rd_last;
  logic [16:0] ce_step;
  logic [15:0] rd_src;

  assign mode      = decode_mode(ctrl_q.wave_sel);
  assign tick      = CNT_CLK & ~cclk_prev_q;
  assign gate_rise = GATE & ~gate_prev_q;

  // write executes once address and data are both held
  assign wr_exec = aw_full_q & w_full_q & ~bvalid_q;
  assign wr_ctrl = wr_exec & w_strb0_q & (aw_addr_q == ITM_OFS_CTRL);
  assign wr_data = wr_exec & w_strb0_q & (aw_addr_q == ITM_OFS_DATA);
  assign rd_exec = S_AXI_ARVALID & ~rvalid_q;
  assign rd_data = rd_exec & (S_AXI_ARADDR == ITM_OFS_DATA);

  assign S_AXI_AWREADY = ~aw_full_q;
  assign S_AXI_WREADY  = ~w_full_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_ARREADY = ~rvalid_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;
  assign TMR_OUT       = out_q;

  // count completes on the last byte the access format asks for
  assign cnt_done = wr_data & ((ctrl_q.fmt != ITM_AF_LOHI) | wr_msb_q);

  // gate pauses modes 0, 2, 3, 4; one-shot modes ignore it once running
  assign count_en = (mode == ITM_MODE1 || mode == ITM_MODE5) ? 1'b1 : GATE;

  // square wave steps by two, except an odd value while high steps one
  assign ce_step = (mode == ITM_MODE3 && !(ce_q[0] && out_q)) ? dec1(dec1(ce_q, ctrl_q.bcd), ctrl_q.bcd)
                                                               : dec1(ce_q, ctrl_q.bcd);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cclk_prev_q <= 1'b0;
      gate_prev_q <= 1'b0;
    end else begin
      cclk_prev_q <= CNT_CLK;
      gate_prev_q <= GATE;
    end
  end

  // write address and data taken in either order
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_full_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb0_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= ITM_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && !aw_full_q) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_full_q) begin
        w_full_q  <= 1'b1;
        w_data_q  <= S_AXI_WDATA;
        w_strb0_q <= S_AXI_WSTRB[0];
      end
      if (wr_exec) begin
        bvalid_q <= 1'b1;
        bresp_q  <= (aw_addr_q == ITM_OFS_CTRL || aw_addr_q == ITM_OFS_DATA) ? ITM_RESP_OKAY : ITM_RESP_SLVERR;
      end
      if (bvalid_q && S_AXI_BREADY) begin
        bvalid_q  <= 1'b0;
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
      end
    end
  end

  // direct read follows the live count unless a latch is held
  assign rd_src  = lat_q ? lat_val_q : ce_q[15:0];
  assign rd_last = (ctrl_q.fmt != ITM_AF_LOHI) | rd_msb_q;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= ITM_RESP_OKAY;
    end else begin
      if (rd_exec) begin
        rvalid_q <= 1'b1;
        rresp_q  <= ITM_RESP_OKAY;
        case (S_AXI_ARADDR)
          ITM_OFS_CTRL:   rdata_q <= {24'h000000, 2'b00, ctrl_q};
          ITM_OFS_DATA: begin
            if (ctrl_q.fmt == ITM_AF_HI || (ctrl_q.fmt == ITM_AF_LOHI && rd_msb_q)) begin
              rdata_q <= {24'h000000, rd_src[15:8]};
            end else begin
              rdata_q <= {24'h000000, rd_src[7:0]};
            end
          end
          ITM_OFS_STATUS: begin
            rdata_q <= 32'h0000_0000;
            rdata_q[ITM_ST_OUT]   <= out_q;
            rdata_q[ITM_ST_RUN]   <= run_q;
            rdata_q[ITM_ST_PEND]  <= pend_q;
            rdata_q[ITM_ST_LATCH] <= lat_q;
          end
          default: begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= ITM_RESP_SLVERR;
          end
        endcase
      end else if (rvalid_q && S_AXI_RREADY) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // read byte pointer and holding latch
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_msb_q  <= 1'b0;
      lat_q     <= 1'b0;
      lat_val_q <= ITM_CR_RESET;
    end else if (wr_ctrl && w_data_q[ITM_BIT_AFHI:ITM_BIT_AFLO] == ITM_AF_LATCH) begin
      if (!lat_q) begin
        lat_q     <= 1'b1;
        lat_val_q <= ce_q[15:0];
      end
    end else if (wr_ctrl) begin
      rd_msb_q <= 1'b0;
      lat_q    <= 1'b0;
    end else if (rd_data) begin
      rd_msb_q <= (ctrl_q.fmt == ITM_AF_LOHI) ? ~rd_msb_q : 1'b0;
      if (rd_last) begin
        lat_q <= 1'b0;
      end
    end
  end

  // control word and count register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q   <= ITM_CTRL_RESET;
      cr_q     <= ITM_CR_RESET;
      wr_msb_q <= 1'b0;
    end else if (wr_ctrl && w_data_q[ITM_BIT_AFHI:ITM_BIT_AFLO] != ITM_AF_LATCH) begin
      ctrl_q   <= w_data_q[5:0];
      wr_msb_q <= 1'b0;
    end else if (wr_data) begin
      case (ctrl_q.fmt)
        ITM_AF_LO:   cr_q <= {8'h00, w_data_q[7:0]};
        ITM_AF_HI:   cr_q <= {w_data_q[7:0], 8'h00};
        ITM_AF_LOHI: begin
          if (wr_msb_q) begin
            cr_q[15:8] <= w_data_q[7:0];
          end else begin
            cr_q[7:0] <= w_data_q[7:0];
          end
          wr_msb_q <= ~wr_msb_q;
        end
        default:     cr_q <= cr_q;
      endcase
    end
  end

  // counting element and output; later assignments take priority
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ce_q     <= ITM_CNT_ZERO;
      out_q    <= 1'b0;
      run_q    <= 1'b0;
      pend_q   <= 1'b0;
      hold_q   <= 1'b0;
      armed_q  <= 1'b0;
      strobe_q <= 1'b0;
    end else begin
      // counter clock edge: a pending load replaces the decrement
      if (tick) begin
        if (strobe_q) begin
          out_q    <= 1'b1;
          strobe_q <= 1'b0;
        end
        if (pend_q && (GATE || (mode != ITM_MODE2 && mode != ITM_MODE3))) begin
          ce_q   <= eff_count(cr_q);
          pend_q <= 1'b0;
          run_q  <= 1'b1;
          if (mode == ITM_MODE1) begin
            out_q <= 1'b0;
          end
        end else if (run_q && !hold_q && count_en) begin
          case (mode)
            ITM_MODE0: begin
              ce_q <= ce_step;
              if (ce_q == ITM_CNT_ONE) begin
                out_q <= 1'b1;
              end
            end
            ITM_MODE1: begin
              ce_q <= ce_step;
              if (ce_q == ITM_CNT_ONE) begin
                out_q <= 1'b1;
                run_q <= 1'b0;
              end
            end
            ITM_MODE2: begin
              // reload only here, so a new count waits for the pulse
              if (ce_q == ITM_CNT_ONE) begin
                ce_q  <= eff_count(cr_q);
                out_q <= 1'b1;
              end else begin
                ce_q  <= ce_step;
                out_q <= (ce_q != ITM_CNT_TWO);
              end
            end
            ITM_MODE3: begin
              if (ce_q == ITM_CNT_TWO) begin
                out_q <= ~out_q;
                // low half of an odd count is one shorter
                ce_q  <= (out_q && cr_q[0]) ? dec1(eff_count(cr_q), ctrl_q.bcd) : eff_count(cr_q);
              end else begin
                ce_q <= ce_step;
              end
            end
            ITM_MODE4,
            ITM_MODE5: begin
              ce_q <= ce_step;
              if (ce_q == ITM_CNT_ONE) begin
                out_q    <= 1'b0;
                strobe_q <= 1'b1;
                run_q    <= 1'b0;
              end
            end
            default: ce_q <= ce_q;
          endcase
        end
      end
      // gate effects
      if ((mode == ITM_MODE2 || mode == ITM_MODE3) && !GATE) begin
        out_q  <= 1'b1;
        run_q  <= 1'b0;
      end
      if (gate_rise && armed_q) begin
        case (mode)
          ITM_MODE1, ITM_MODE5, ITM_MODE2, ITM_MODE3, ITM_MODE4: pend_q <= 1'b1;
          default: pend_q <= pend_q;
        endcase
      end
      // count writes from the bus
      if (wr_data && !cnt_done && mode == ITM_MODE0) begin
        hold_q <= 1'b1;
      end
      if (cnt_done) begin
        armed_q <= 1'b1;
        hold_q  <= 1'b0;
        case (mode)
          ITM_MODE0: begin
            pend_q <= 1'b1;
            out_q  <= 1'b0;
          end
          ITM_MODE4: pend_q <= 1'b1;
          ITM_MODE2: pend_q <= ~run_q;
          ITM_MODE3: pend_q <= 1'b1;
          default:   pend_q <= pend_q;
        endcase
      end
      // control word resets the channel
      if (wr_ctrl && w_data_q[ITM_BIT_AFHI:ITM_BIT_AFLO] != ITM_AF_LATCH) begin
        ce_q     <= ITM_CNT_ZERO;
        out_q    <= (decode_mode(w_data_q[ITM_BIT_WSEL2:ITM_BIT_WSEL0]) != ITM_MODE0);
        run_q    <= 1'b0;
        pend_q   <= 1'b0;
        hold_q   <= 1'b0;
        armed_q  <= 1'b0;
        strobe_q <= 1'b0;
      end
    end
  end

endmodule // itm_timer
`default_nettype wire

//--- include/itm_pkg.sv
// constants, field layouts and types for the interval timer channel
`default_nettype none
package itm_pkg;

  // register byte offsets
  localparam logic [7:0] ITM_OFS_CTRL   = 8'h00;
  localparam logic [7:0] ITM_OFS_DATA   = 8'h04;
  localparam logic [7:0] ITM_OFS_STATUS = 8'h08;

  // control word field positions
  localparam int ITM_BIT_BCD    = 0;
  localparam int ITM_BIT_WSEL0  = 1;
  localparam int ITM_BIT_WSEL1  = 2;
  localparam int ITM_BIT_WSEL2  = 3;
  localparam int ITM_BIT_AFLO   = 4;
  localparam int ITM_BIT_AFHI   = 5;

  // status field positions
  localparam int ITM_ST_OUT     = 0;
  localparam int ITM_ST_RUN     = 1;
  localparam int ITM_ST_PEND    = 2;
  localparam int ITM_ST_LATCH   = 3;

  // axi response codes
  localparam logic [1:0] ITM_RESP_OKAY   = 2'b00;
  localparam logic [1:0] ITM_RESP_SLVERR = 2'b10;

  // count constants
  localparam logic [16:0] ITM_CNT_MAX  = 17'h10000;
  localparam logic [16:0] ITM_CNT_ONE  = 17'h00001;
  localparam logic [16:0] ITM_CNT_TWO  = 17'h00002;
  localparam logic [16:0] ITM_CNT_ZERO = 17'h00000;
  localparam logic [3:0]  ITM_BCD_NINE = 4'h9;
  localparam logic [15:0] ITM_CR_RESET = 16'h0000;

  // access formats
  typedef enum logic [1:0] {
    ITM_AF_LATCH = 2'b00,
    ITM_AF_LO    = 2'b01,
    ITM_AF_HI    = 2'b10,
    ITM_AF_LOHI  = 2'b11
  } itm_fmt_t;

  typedef enum logic [2:0] {
    ITM_MODE0, ITM_MODE1, ITM_MODE2, ITM_MODE3, ITM_MODE4, ITM_MODE5
  } itm_mode_t;

  typedef struct packed {
    itm_fmt_t  fmt;
    logic [2:0] wave_sel;
    logic       bcd;
  } itm_ctrl_t;

  localparam itm_ctrl_t ITM_CTRL_RESET = '{fmt: ITM_AF_LO, wave_sel: 3'h0, bcd: 1'b0};

endpackage
`default_nettype wire

//--- sim/itm_timer_asserts.sv
// concurrent checks on the timer channel ports
`timescale 1ns/100ps
`default_nettype none
module itm_timer_asserts
  import itm_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic        CNT_CLK,
  input wire logic        GATE,
  input wire logic        TMR_OUT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // reset has to be seen, so this one is never disabled
  a_reset_idle: assert property (disable iff (1'b0) !RST_N |-> !S_AXI_BVALID && !S_AXI_RVALID && !TMR_OUT)
    else $error("outputs not idle in reset");
  a_b_after_both: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |-> ##[1:2] S_AXI_BVALID) else $error("write response late");
  a_b_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  a_r_after_ar: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read data late");
  a_r_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  a_ar_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("read address taken early");
  a_aw_busy: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while busy");
  a_rdata_byte: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
    else $error("read data wider than a byte");
  // output moves only on a count tick, a gate change or a register write
  a_out_cause: assert property ($changed(TMR_OUT) |-> ($past(CNT_CLK) && !$past(CNT_CLK, 2))
    || ($past(CNT_CLK, 2) && !$past(CNT_CLK, 3)) || ($past(GATE) != $past(GATE, 2))
    || ($past(GATE, 2) != $past(GATE, 3)) || $rose(S_AXI_BVALID))
    else $error("output changed without cause");
  c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
  c_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
  c_out_fall: cover property ($fell(TMR_OUT));
endmodule // itm_timer_asserts
bind itm_timer itm_timer_asserts u_chk (.CLK(CLK), .RST_N(RST_N), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .CNT_CLK(CNT_CLK), .GATE(GATE),
  .TMR_OUT(TMR_OUT));
`default_nettype wire

//--- sim/itm_cnt_src.sv
// counter clock source standing for the far side of the channel
`timescale 1ns/100ps
`default_nettype none
module itm_cnt_src (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic en,
  output logic      cnt_clk
);
  logic [1:0] ph_q;
  // stands still low when disabled so a direct read sees a frozen count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_q <= 2'h0;
    end else begin
      ph_q <= en ? ph_q + 2'h1 : 2'h0;
    end
  end
  assign cnt_clk = ph_q[1];
endmodule // itm_cnt_src
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench for the interval timer channel
`timescale 1ns/100ps
`default_nettype none
module testbench
  import itm_pkg::*;
;
  typedef struct {logic [7:0] ctl; logic [15:0] cnt; logic lvl; int t1, t2, t3; logic trig;} itm_row_t;
  logic        clk = 1'b0;
  logic        rst_n, awvalid, wvalid, bready, arvalid, rready, en, gate, slow;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdv;
  logic [3:0]  wstrb;
  logic [1:0]  rsp;
  wire logic   awready, wready, bvalid, arready, rvalid, cnt_clk, tmr_out;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  int          n_errors, checks, cyc, i;
  // ticks to first change, then lengths of the next two levels; 20 means no change
  itm_row_t rows [10] = '{
    '{8'h14, 16'h0004, 1'b1, 4, 1, 3, 1'b0},
    '{8'h1C, 16'h0004, 1'b1, 4, 1, 3, 1'b1},
    '{8'h10, 16'h0005, 1'b0, 6, 20, 20, 1'b0},
    '{8'h30, 16'h0003, 1'b0, 4, 20, 20, 1'b0},
    '{8'h18, 16'h0004, 1'b1, 5, 1, 20, 1'b0},
    '{8'h16, 16'h0004, 1'b1, 0, 2, 2, 1'b0},
    '{8'h1E, 16'h0005, 1'b1, 0, 2, 3, 1'b0},
    '{8'h12, 16'h0003, 1'b1, 1, 3, 20, 1'b1},
    '{8'h1A, 16'h0003, 1'b1, 4, 1, 20, 1'b1},
    '{8'h15, 16'h0010, 1'b1, 10, 1, 9, 1'b0}};
  itm_timer DUT (.CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .CNT_CLK(cnt_clk),
    .GATE(gate), .TMR_OUT(tmr_out));
  itm_cnt_src u_src (.clk(clk), .rst_n(rst_n), .en(en), .cnt_clk(cnt_clk));
  always #4 clk = ~clk;
  task automatic tally_and_finish();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // slow holds the response ready back to make the slave wait
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int k;
    logic aw, w, b;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !slow;
    aw = 1'b0;
    w = 1'b0;
    b = 1'b0;
    for (k = 0; !b; k++) begin
      @(posedge clk);
      b = aw && w && bvalid && bready;
      aw = aw || awready;
      w = w || wready;
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (k == 3) bready <= 1'b1;
    end
    bready <= 1'b0;
    rsp = bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    int k;
    logic ar, r;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= !slow;
    ar = 1'b0;
    r = 1'b0;
    for (k = 0; !r; k++) begin
      @(posedge clk);
      r = ar && rvalid && rready;
      ar = ar || arready;
      if (ar) arvalid <= 1'b0;
      if (k == 3) rready <= 1'b1;
    end
    rready <= 1'b0;
    rdv = rdata;
    rsp = rresp;
  endtask
  task automatic prog(input logic [7:0] c, input logic [15:0] n);
    wr(ITM_OFS_CTRL, c);
    if (c[ITM_BIT_AFLO]) wr(ITM_OFS_DATA, n[7:0]);
    if (c[ITM_BIT_AFHI]) wr(ITM_OFS_DATA, n[15:8]);
  endtask
  task automatic run(input int n);
    en <= 1'b1;
    repeat (4 * n) @(posedge clk);
    en <= 1'b0;
  endtask
  // one tick every four clocks; sampled well after each tick has landed
  task automatic meas(input logic lvl, input int t1, input int t2, input int t3);
    int k, c, s;
    int seg [3];
    logic cur;
    chk("level", {31'h0, lvl}, {31'h0, tmr_out});
    en <= 1'b1;
    gate <= 1'b1;
    @(posedge clk);
    cur = lvl;
    c = 0;
    s = 0;
    for (k = 0; k < 64 && s < 3; k++) begin
      repeat (4) @(posedge clk);
      #1;
      c++;
      if (tmr_out !== cur || c == 20) begin
        seg[s] = c;
        s++;
        c = 0;
        cur = tmr_out;
      end
    end
    @(posedge clk);
    en <= 1'b0;
    if (t1 != 0) chk("first", t1, seg[0]);
    chk("second", t2, seg[1]);
    chk("third", t3, seg[2]);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, en, slow} = 7'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    gate = 1'b1;
    rst_n = 1'b1;
    n_errors = 0;
    checks = 0;
    cyc = 0;
    #1 rst_n = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk("out reset", 32'h0, {31'h0, tmr_out});
    rd(ITM_OFS_CTRL);
    chk("ctrl reset", 32'h00000010, rdv);
    rd(ITM_OFS_STATUS);
    chk("status reset", 32'h0, rdv);
    for (i = 0; i < 10; i++) begin
      gate <= !rows[i].trig;
      prog(rows[i].ctl, rows[i].cnt);
      meas(rows[i].lvl, rows[i].t1, rows[i].t2, rows[i].t3);
    end
    prog(8'h10, 16'h0008);
    run(3);
    wr(ITM_OFS_DATA, 8'h02);
    meas(1'b0, 3, 20, 20);
    prog(8'h14, 16'h0003);
    en <= 1'b1;
    repeat (12) @(posedge clk);
    #1;
    chk("pulse", 32'h0, {31'h0, tmr_out});
    @(posedge clk);
    gate <= 1'b0;
    @(posedge clk);
    #1;
    chk("gate low", 32'h1, {31'h0, tmr_out});
    @(posedge clk);
    en <= 1'b0;
    gate <= 1'b1;
    prog(8'h16, 16'h000A);
    run(2);
    rd(ITM_OFS_DATA);
    chk("by two", 32'h08, rdv);
    prog(8'h30, 16'h0000);
    run(3);
    rd(ITM_OFS_DATA);
    chk("zero lo", 32'hFE, rdv);
    rd(ITM_OFS_DATA);
    chk("zero hi", 32'hFF, rdv);
    wr(ITM_OFS_CTRL, 8'h00);
    rd(ITM_OFS_STATUS);
    chk("status latch", 32'h0000000A, rdv);
    run(3);
    rd(ITM_OFS_DATA);
    chk("latch lo", 32'hFE, rdv);
    rd(ITM_OFS_DATA);
    chk("latch hi", 32'hFF, rdv);
    rd(ITM_OFS_DATA);
    chk("live lo", 32'hFB, rdv);
    prog(8'h20, 16'h0500);
    run(2);
    rd(ITM_OFS_DATA);
    chk("hi only", 32'h04, rdv);
    prog(8'h18, 16'h0005);
    chk("out mode4", 32'h1, {31'h0, tmr_out});
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk("out mid reset", 32'h0, {31'h0, tmr_out});
    rd(ITM_OFS_CTRL);
    chk("ctrl mid reset", 32'h00000010, rdv);
    wstrb <= 4'h0;
    wr(ITM_OFS_CTRL, 8'h16);
    wstrb <= 4'hF;
    rd(ITM_OFS_CTRL);
    chk("strobe off", 32'h00000010, rdv);
    slow = 1'b1;
    wr(8'h0C, 8'h55);
    chk("bad write", {30'h0, ITM_RESP_SLVERR}, {30'h0, rsp});
    rd(8'h0C);
    chk("bad read", {30'h0, ITM_RESP_SLVERR}, {30'h0, rsp});
    chk("bad data", 32'h0, rdv);
    slow = 1'b0;
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
